/* File: core/cmbf_top.sv */
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module cmbf_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic rx_wr,
    input wire logic [3:0] rx_idx,
    input wire logic [7:0] rx_byte,
    input wire logic rx_done,
    input wire logic rx_ok,
    input wire logic arb_start,
    input wire logic arb_lost,
    input wire logic tx_done,
    input wire logic tx_err,
    input wire logic [3:0] tx_rd_idx,
    output logic [7:0] tx_rd_data,
    output logic tx_req,
    output logic tx_active,
    output logic [1:0] tx_sel,
    output logic ack_en,
    output logic loopback,
    output logic rx_irq,
    output logic err_irq,
    output logic tx_irq
);
    import cmbf_pkg::*;

    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rdata;
    logic [2:0] ctrl_r;
    cmbf_mode_t mode_r;
    logic [31:0] pat_r [2];
    logic [31:0] msk_r [2];
    logic [BUF_BYTES*8-1:0] bg_r;
    logic [BUF_BYTES*8-1:0] fg_r;
    logic [BUF_BYTES*8-1:0] tx_r [NUM_TX];
    logic [LOCAL_PRIORITY_FIELD_W-1:0] local_priority_field_r [NUM_TX];
    logic rxf_r;
    logic ovr_r;
    logic bg_full_r;
    logic [HIT_W-1:0] hit_r;
    logic [HIT_W-1:0] bg_hit_r;
    logic [NUM_TX-1:0] txe_r;
    logic [NUM_TX-1:0] abort_acknowledge_flag_r;
    logic [NUM_TX-1:0] abort_request_flag_r;
    logic [NUM_TX-1:0] txeie_r;
    logic tx_active_r;
    logic [1:0] tx_sel_r;
    logic [7:0] tx_rd_r;

    cmbf_filt_if fb0 ();
    cmbf_filt_if fb1 ();

    // Address phase capture; every transfer completes without wait states.
    wire addr_ok = hsel && htrans[1] && hready;
    wire [7:0] rd_a = haddr[7:0];
    wire w_ctrl = wr_pend_r && (addr_r == A_CTRL);
    wire w_rflg = wr_pend_r && (addr_r == A_RFLG);
    wire w_tflg = wr_pend_r && (addr_r == A_TFLG);
    wire w_tctl = wr_pend_r && (addr_r == A_TCTL);
    wire w_idac = wr_pend_r && (addr_r == A_IDAC);
    wire w_pat0 = wr_pend_r && (addr_r == A_PAT0);
    wire w_pat1 = wr_pend_r && (addr_r == A_PAT1);
    wire w_msk0 = wr_pend_r && (addr_r == A_MSK0);
    wire w_msk1 = wr_pend_r && (addr_r == A_MSK1);
    wire loop_w = ctrl_r[C_LOOP];

    // Filter inputs: identifier bytes 0 to 3 of the frame in the background buffer.
    wire [31:0] id_w = {bg_r[7:0], bg_r[15:8], bg_r[23:16], bg_r[31:24]};
    assign fb0.id = id_w;
    assign fb0.pat = pat_r[0];
    assign fb0.msk = msk_r[0];
    assign fb0.mode = mode_r;
    assign fb1.id = id_w;
    assign fb1.pat = pat_r[1];
    assign fb1.msk = msk_r[1];
    assign fb1.mode = mode_r;

    cmbf_filter u_flt0 (.f(fb0));
    cmbf_filter u_flt1 (.f(fb1));

    logic [7:0] h8;
    logic [HIT_W-1:0] hit_idx;
    always_comb begin
        case (mode_r)
            CMBF_WIDE: h8 = {6'h00, fb1.hit[0], fb0.hit[0]};
            CMBF_MEDIUM: h8 = {4'h0, fb1.hit[1:0], fb0.hit[1:0]};
            CMBF_NARROW: h8 = {fb1.hit, fb0.hit};
            default: h8 = 8'h00;
        endcase
        hit_idx = '0;
        for (int i = 7; i >= 0; i--) begin
            if (h8[i]) begin
                hit_idx = HIT_W'(i);
            end
        end
    end

    // Receive path. Own frames are filtered out here unless loop-back is on.
    wire own = tx_active_r && !loop_w;
    wire accept = rx_done && rx_ok && !own && (|h8);
    wire rxf_clr = w_rflg && hwdata[R_RXF];
    wire ovr_clr = w_rflg && hwdata[R_OVR];
    wire copy_bg = bg_full_r && (!rxf_r || rxf_clr);
    wire copy_new = accept && !rxf_r && !bg_full_r;
    wire hold_new = accept && rxf_r && !bg_full_r;
    wire ovr_ev = accept && bg_full_r;
    wire fg_load = copy_bg || copy_new;
    // A held frame must survive until it moves forward, so writes stop then.
    wire bg_wr = rx_wr && !bg_full_r && (rx_idx < 4'(BUF_BYTES));

    // Transmit path.
    wire [NUM_TX-1:0] pend = ~txe_r;
    logic [1:0] best;
    logic best_ok;
    always_comb begin
        best = 2'h0;
        for (int n = NUM_TX - 1; n >= 0; n--) begin
            if (pend[n] && (!pend[best] || local_priority_field_r[n] <= local_priority_field_r[best])) begin
                best = 2'(n);
            end
        end
        best_ok = 1'b1;
        for (int n = 0; n < NUM_TX; n++) begin
            if (pend[n] && local_priority_field_r[n] < local_priority_field_r[best]) begin
                best_ok = 1'b0;
            end
        end
    end

    logic [NUM_TX-1:0] done_set;
    logic [NUM_TX-1:0] grant;
    logic [NUM_TX-1:0] tx_wsel;
    for (genvar n = 0; n < NUM_TX; n++) begin : g_tx
        assign done_set[n] = tx_done && tx_active_r && (tx_sel_r == 2'(n));
        assign grant[n] = abort_request_flag_r[n] && !txe_r[n]
                        && !(tx_active_r && tx_sel_r == 2'(n));
        // Buffers that are scheduled are locked against software writes.
        assign tx_wsel[n] = wr_pend_r && txe_r[n]
                          && (addr_r[7:4] == A_TX0_HI + 4'(n));
    end
    wire [NUM_TX-1:0] txe_clr = w_tflg ? hwdata[T_TXE_LSB +: NUM_TX] : '0;
    wire [NUM_TX-1:0] abt_set = w_tctl ? (hwdata[X_ABORT_REQUEST_FLAG_LSB +: NUM_TX] & pend) : '0;

    // Read mux, sampled in the address phase and returned from a register.
    wire [127:0] fg_ext = {24'h0, fg_r};
    logic [127:0] tx_ext [NUM_TX];
    always_comb begin
        for (int n = 0; n < NUM_TX; n++) begin
            tx_ext[n] = {16'h0, local_priority_field_r[n], tx_r[n]};
        end
        rdata = 32'h0000_0000;
        case (rd_a)
            A_CTRL: rdata = {29'h0, ctrl_r};
            A_RFLG: rdata = {30'h0, ovr_r, rxf_r};
            A_TFLG: rdata = {25'h0, abort_acknowledge_flag_r, 1'b0, txe_r};
            A_TCTL: rdata = {25'h0, txeie_r, 1'b0, abort_request_flag_r};
            A_IDAC: rdata = {25'h0, hit_r, 2'h0, mode_r};
            A_PAT0: rdata = pat_r[0];
            A_PAT1: rdata = pat_r[1];
            A_MSK0: rdata = msk_r[0];
            A_MSK1: rdata = msk_r[1];
            default: begin
                if (rd_a[7:4] == A_FG_HI) begin
                    rdata = fg_ext[32*rd_a[3:2] +: 32];
                end else if (rd_a[7:4] >= A_TX0_HI && rd_a[7:4] < A_TX0_HI + 4'(NUM_TX)) begin
                    rdata = tx_ext[rd_a[5:4] - 2'h1][32*rd_a[3:2] +: 32];
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            addr_r <= rd_a;
            hrdata_r <= (addr_ok && !hwrite) ? rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= 3'h0;
            mode_r <= CMBF_WIDE;
            pat_r[0] <= PAT_RST;
            pat_r[1] <= PAT_RST;
            msk_r[0] <= MSK_RST;
            msk_r[1] <= MSK_RST;
            txeie_r <= '0;
        end else begin
            if (w_ctrl) ctrl_r <= hwdata[2:0];
            if (w_idac) mode_r <= cmbf_mode_t'(hwdata[I_MODE_LSB +: 2]);
            if (w_pat0) pat_r[0] <= hwdata;
            if (w_pat1) pat_r[1] <= hwdata;
            if (w_msk0) msk_r[0] <= hwdata;
            if (w_msk1) msk_r[1] <= hwdata;
            if (w_tctl) txeie_r <= hwdata[X_TXEIE_LSB +: NUM_TX];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bg_r <= '0;
            fg_r <= '0;
            rxf_r <= 1'b0;
            ovr_r <= 1'b0;
            bg_full_r <= 1'b0;
            hit_r <= '0;
            bg_hit_r <= '0;
        end else begin
            if (bg_wr) bg_r[8*rx_idx +: 8] <= rx_byte;
            if (fg_load) begin
                fg_r <= bg_r;
                hit_r <= copy_bg ? bg_hit_r : hit_idx;
            end
            rxf_r <= (rxf_r && !rxf_clr) || fg_load;
            ovr_r <= (ovr_r && !ovr_clr) || ovr_ev;
            if (hold_new) begin
                bg_full_r <= 1'b1;
                bg_hit_r <= hit_idx;
            end else if (copy_bg) begin
                bg_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int n = 0; n < NUM_TX; n++) begin
                tx_r[n] <= '0;
                local_priority_field_r[n] <= '0;
            end
        end else begin
            for (int n = 0; n < NUM_TX; n++) begin
                for (int k = 0; k < BUF_BYTES; k++) begin
                    if (tx_wsel[n] && addr_r[3:2] == 2'(k / 4)) begin
                        tx_r[n][8*k +: 8] <= hwdata[8*(k % 4) +: 8];
                    end
                end
                if (tx_wsel[n] && addr_r[3:2] == 2'h3) begin
                    local_priority_field_r[n] <= hwdata[LOCAL_PRIORITY_FIELD_LSB +: LOCAL_PRIORITY_FIELD_W];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txe_r <= TXE_RST;
            abort_acknowledge_flag_r <= '0;
            abort_request_flag_r <= '0;
            tx_active_r <= 1'b0;
            tx_sel_r <= 2'h0;
            tx_rd_r <= 8'h00;
        end else begin
            txe_r <= (txe_r & ~txe_clr) | done_set | grant;
            abort_acknowledge_flag_r <= (abort_acknowledge_flag_r & ~done_set & ~txe_clr) | grant;
            abort_request_flag_r <= (abort_request_flag_r | abt_set) & ~grant & ~done_set;
            if (arb_start) begin
                tx_active_r <= |pend;
                tx_sel_r <= best;
            end else if (tx_done || tx_err || arb_lost) begin
                tx_active_r <= 1'b0;
            end
            if (tx_rd_idx < 4'(BUF_BYTES)) tx_rd_r <= tx_r[tx_sel_r][8*tx_rd_idx +: 8];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign tx_req = |pend;
    assign tx_active = tx_active_r;
    assign tx_sel = tx_sel_r;
    assign tx_rd_data = tx_rd_r;
    assign ack_en = !own;
    assign loopback = loop_w;
    assign rx_irq = rxf_r && ctrl_r[C_RXFIE];
    assign err_irq = ovr_r && ctrl_r[C_OVRIE];
    assign tx_irq = |(txe_r & txeie_r);

    property p_copy;
        @(posedge hclk) disable iff (!hresetn)
        copy_new |=> rxf_r && (fg_r == $past(bg_r));
    endproperty
    a_copy: assert property (p_copy) else $error("accepted frame not moved forward");
    property p_closed;
        @(posedge hclk) disable iff (!hresetn)
        (mode_r == CMBF_CLOSED) && !rxf_r && !bg_full_r |=> !rxf_r;
    endproperty
    a_closed: assert property (p_closed) else $error("closed mode set receive full");
    property p_own;
        @(posedge hclk) disable iff (!hresetn)
        rx_done && own && !bg_full_r |=> $stable(fg_r) && !ack_en == $past(own);
    endproperty
    a_own: assert property (p_own) else $error("own frame reached foreground");
    property p_ovr;
        @(posedge hclk) disable iff (!hresetn)
        accept && bg_full_r && rxf_r && !rxf_clr |=> ovr_r && bg_full_r && $stable(fg_r);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");
    property p_local_priority_field;
        @(posedge hclk) disable iff (!hresetn)
        arb_start && tx_req |-> best_ok ##1 tx_active_r;
    endproperty
    a_local_priority_field: assert property (p_local_priority_field) else $error("wrong buffer chosen");
    property p_done;
        @(posedge hclk) disable iff (!hresetn)
        tx_done && tx_active_r |=> txe_r[$past(tx_sel_r)] && !abort_acknowledge_flag_r[$past(tx_sel_r)];
    endproperty
    a_done: assert property (p_done) else $error("sent buffer not released");
    property p_noabort;
        @(posedge hclk) disable iff (!hresetn)
        tx_active_r && pend[tx_sel_r] && !tx_done |=> !abort_acknowledge_flag_r[$past(tx_sel_r)];
    endproperty
    a_noabort: assert property (p_noabort) else $error("active frame aborted");
    property p_hit;
        @(posedge hclk) disable iff (!hresetn)
        copy_new |=> ((($past(h8) >> hit_r) & 8'h01) == 8'h01)
            && (($past(h8) & ((8'h01 << hit_r) - 8'h01)) == 8'h00);
    endproperty
    a_hit: assert property (p_hit) else $error("hit is not lowest match");
    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        rxf_clr && bg_full_r |=> rxf_r && !bg_full_r;
    endproperty
    a_hold: assert property (p_hold) else $error("held frame not promoted");
endmodule

/* File: core/cmbf_pkg.sv */
package cmbf_pkg;
    localparam int BUF_BYTES = 13;
    localparam int NUM_TX = 3;
    localparam int LOCAL_PRIORITY_FIELD_W = 8;
    localparam int HIT_W = 3;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_RFLG = 8'h04;
    localparam logic [7:0] A_TFLG = 8'h08;
    localparam logic [7:0] A_TCTL = 8'h0c;
    localparam logic [7:0] A_IDAC = 8'h10;
    localparam logic [7:0] A_PAT0 = 8'h14;
    localparam logic [7:0] A_PAT1 = 8'h18;
    localparam logic [7:0] A_MSK0 = 8'h1c;
    localparam logic [7:0] A_MSK1 = 8'h20;
    localparam logic [3:0] A_FG_HI = 4'h4;
    localparam logic [3:0] A_TX0_HI = 4'h5;

    localparam int C_LOOP = 0;
    localparam int C_RXFIE = 1;
    localparam int C_OVRIE = 2;
    localparam int R_RXF = 0;
    localparam int R_OVR = 1;
    localparam int T_TXE_LSB = 0;
    localparam int T_ABORT_ACKNOWLEDGE_FLAG_LSB = 4;
    localparam int X_ABORT_REQUEST_FLAG_LSB = 0;
    localparam int X_TXEIE_LSB = 4;
    localparam int I_MODE_LSB = 0;
    localparam int I_HIT_LSB = 4;
    localparam int LOCAL_PRIORITY_FIELD_LSB = 8;

    localparam logic [2:0] TXE_RST = 3'h7;
    localparam logic [31:0] PAT_RST = 32'h0000_0000;
    localparam logic [31:0] MSK_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        CMBF_WIDE,
        CMBF_MEDIUM,
        CMBF_NARROW,
        CMBF_CLOSED
    } cmbf_mode_t;
endpackage

/* File: core/cmbf_filt_if.sv */
`timescale 1ns/1ps
interface cmbf_filt_if;
    logic [31:0] id;
    logic [31:0] pat;
    logic [31:0] msk;
    cmbf_pkg::cmbf_mode_t mode;
    logic [3:0] hit;
    modport top (output id, output pat, output msk, output mode, input hit);
    modport filt (input id, input pat, input msk, input mode, output hit);
endinterface

/* File: core/cmbf_filter.sv */
`timescale 1ns/1ps
// One bank of four pattern and four mask bytes. A mask bit of one makes
// the matching identifier bit a don't-care.
module cmbf_filter (
    cmbf_filt_if.filt f
);
    import cmbf_pkg::*;

    logic [3:0] m_full;
    logic [3:0] m_pair;
    logic [3:0] m_one;

    function automatic logic bmatch(input logic [7:0] a, input logic [7:0] p,
                                    input logic [7:0] m);
        bmatch = (((a ^ p) & ~m) == 8'h00);
    endfunction

    for (genvar k = 0; k < 4; k++) begin : g_byte
        assign m_full[k] = bmatch(f.id[31-8*k -: 8], f.pat[31-8*k -: 8], f.msk[31-8*k -: 8]);
        assign m_pair[k] = bmatch(f.id[31-8*(k%2) -: 8], f.pat[31-8*k -: 8],
                                  f.msk[31-8*k -: 8]);
        assign m_one[k] = bmatch(f.id[31:24], f.pat[31-8*k -: 8], f.msk[31-8*k -: 8]);
    end

    always_comb begin
        case (f.mode)
            CMBF_WIDE: f.hit = {3'h0, &m_full};
            CMBF_MEDIUM: f.hit = {2'h0, &m_pair[3:2], &m_pair[1:0]};
            CMBF_NARROW: f.hit = m_one;
            default: f.hit = 4'h0;
        endcase
    end
endmodule

/* File: bench/cmbf_can_model.sv */
`timescale 1ns/1ps
// Stand-in for the bit engine that faces the CAN bus. Released data lines
// carry the inverse of their last value so no check can lean on a stale byte.
module cmbf_can_model (
    input wire logic clk,
    output logic rx_wr,
    output logic [3:0] rx_idx,
    output logic [7:0] rx_byte,
    output logic rx_done,
    output logic rx_ok,
    output logic arb_start,
    output logic arb_lost,
    output logic tx_done,
    output logic tx_err,
    output logic [3:0] tx_rd_idx
);
    logic [3:0] ev_r;

    assign {tx_err, tx_done, arb_lost, arb_start} = ev_r;

    initial begin
        ev_r = 4'h0;
        rx_wr = 1'b0;
        rx_idx = 4'h0;
        rx_byte = 8'h00;
        rx_done = 1'b0;
        rx_ok = 1'b0;
        tx_rd_idx = 4'h0;
    end

    // Bytes 0 to 3 carry the identifier most significant byte first.
    task automatic frame(input logic [31:0] id, input logic ok);
        for (int k = 0; k < 13; k++) begin
            @(posedge clk);
            rx_wr <= 1'b1;
            rx_idx <= k[3:0];
            rx_byte <= (k < 4) ? id[31 - 8 * k -: 8] : k[7:0];
        end
        @(posedge clk);
        rx_wr <= 1'b0;
        rx_idx <= ~rx_idx;
        rx_byte <= ~rx_byte;
        rx_done <= 1'b1;
        rx_ok <= ok;
        @(posedge clk);
        rx_done <= 1'b0;
        rx_ok <= ~ok;
        @(posedge clk);
        #1;
    endtask

    // Moves the fetch index; the byte comes back registered, so wait two edges.
    task automatic fetch(input logic [3:0] i);
        @(posedge clk);
        tx_rd_idx <= i;
        @(posedge clk);
        @(posedge clk);
        #1;
    endtask

    // One-cycle event: bit 0 start, 1 lost, 2 done, 3 error.
    task automatic pulse(input logic [3:0] v);
        @(posedge clk);
        ev_r <= v;
        @(posedge clk);
        ev_r <= 4'h0;
        @(posedge clk);
        #1;
    endtask
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import cmbf_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, tx_sel;
    logic [2:0] hsize;
    logic rx_wr, rx_done, rx_ok, arb_start, arb_lost, tx_done, tx_err;
    logic [3:0] rx_idx, tx_rd_idx;
    logic [7:0] rx_byte, tx_rd_data;
    logic tx_req, tx_active, ack_en, loopback, rx_irq, err_irq, tx_irq;
    int err_count, comparisons, cycles;

    cmbf_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .rx_wr(rx_wr), .rx_idx(rx_idx), .rx_byte(rx_byte), .rx_done(rx_done),
        .rx_ok(rx_ok), .arb_start(arb_start), .arb_lost(arb_lost), .tx_done(tx_done),
        .tx_err(tx_err), .tx_rd_idx(tx_rd_idx), .tx_rd_data(tx_rd_data),
        .tx_req(tx_req), .tx_active(tx_active), .tx_sel(tx_sel), .ack_en(ack_en),
        .loopback(loopback), .rx_irq(rx_irq), .err_irq(err_irq), .tx_irq(tx_irq));

    cmbf_can_model eng (.clk(hclk), .rx_wr(rx_wr), .rx_idx(rx_idx), .rx_byte(rx_byte),
        .rx_done(rx_done), .rx_ok(rx_ok), .arb_start(arb_start), .arb_lost(arb_lost),
        .tx_done(tx_done), .tx_err(tx_err), .tx_rd_idx(tx_rd_idx));

    always #2.5 hclk = ~hclk;

    task automatic finish_test;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            finish_test;
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(n, q, e);
    endtask

    function automatic logic [31:0] fgw(input logic [31:0] id);
        return {id[7:0], id[15:8], id[23:16], id[31:24]};
    endfunction

    task automatic txb(input logic [3:0] n, input logic [7:0] b0, input logic [7:0] pr);
        wr({A_TX0_HI + n, 4'h0}, {24'h0, b0});
        wr({A_TX0_HI + n, 4'hc}, {16'h0, pr, ~b0});
    endtask

    task automatic t_reset;
        rd("tflg reset", A_TFLG, {29'h0, TXE_RST});
        rd("rflg reset", A_RFLG, 32'h0);
        rd("idac reset", A_IDAC, 32'h0);
        rd("pat reset", A_PAT1, PAT_RST);
        rd("unmapped", 8'hfc, 32'h0);
    endtask

    task automatic t_rx;
        wr(A_PAT0, 32'h11223344);
        eng.frame(32'h11223344, 1'b0);
        rd("rflg bad frame", A_RFLG, 32'h0);
        eng.frame(32'h11223345, 1'b1);
        rd("rflg miss", A_RFLG, 32'h0);
        eng.frame(32'h11223344, 1'b1);
        rd("rflg hit", A_RFLG, 32'h1);
        chk("rx_irq masked", {31'h0, rx_irq}, 32'h0);
        wr(A_CTRL, 32'h2);
        chk("rx_irq", {31'h0, rx_irq}, 32'h1);
        rd("fg id", {A_FG_HI, 4'h0}, fgw(32'h11223344));
        rd("fg data", {A_FG_HI, 4'h4}, 32'h07060504);
        wr(A_RFLG, 32'h1);
        rd("rflg clear", A_RFLG, 32'h0);
        chk("rx_irq off", {31'h0, rx_irq}, 32'h0);
    endtask

    // The third frame arrives while both stages are full and must be lost.
    task automatic t_ovr;
        wr(A_CTRL, 32'h6);
        wr(A_MSK0, 32'h000000ff);
        eng.frame(32'h11223301, 1'b1);
        eng.frame(32'h11223302, 1'b1);
        rd("rflg held", A_RFLG, 32'h1);
        eng.frame(32'h11223303, 1'b1);
        rd("rflg ovr", A_RFLG, 32'h3);
        chk("err_irq", {31'h0, err_irq}, 32'h1);
        rd("fg first", {A_FG_HI, 4'h0}, fgw(32'h11223301));
        wr(A_RFLG, 32'h3);
        rd("rflg refill", A_RFLG, 32'h1);
        rd("fg second", {A_FG_HI, 4'h0}, fgw(32'h11223302));
        chk("err_irq off", {31'h0, err_irq}, 32'h0);
        wr(A_RFLG, 32'h1);
        rd("rflg empty", A_RFLG, 32'h0);
        wr(A_MSK0, 32'h0);
    endtask

    task automatic t_modes;
        logic [1:0] md [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
        logic [31:0] id [5] = '{32'h55667788, 32'h77880000, 32'h66000000,
                                32'h99000000, 32'h11223344};
        logic [31:0] ex [5] = '{32'h10, 32'h31, 32'h52, 32'h0, 32'h0};
        wr(A_PAT1, 32'h55667788);
        for (int i = 0; i < 5; i++) begin
            wr(A_IDAC, {30'h0, md[i]});
            eng.frame(id[i], 1'b1);
            rd("rflg mode", A_RFLG, {31'h0, ex[i] != 32'h0});
            if (ex[i] != 32'h0) begin
                rd("idac hit", A_IDAC, ex[i]);
                wr(A_RFLG, 32'h1);
            end
        end
        wr(A_IDAC, 32'h0);
        wr(A_MSK0, 32'hffffffff);
        eng.frame(32'h55667788, 1'b1);
        rd("idac lowest", A_IDAC, 32'h0);
        wr(A_RFLG, 32'h1);
        wr(A_MSK0, 32'h0);
    endtask

    task automatic t_tx;
        wr(A_TCTL, 32'h70);
        txb(4'h0, 8'ha0, 8'h1e);
        txb(4'h2, 8'ha2, 8'h0a);
        wr(A_TFLG, 32'h5);
        chk("tx_req", {31'h0, tx_req}, 32'h1);
        eng.pulse(4'h1);
        chk("sel local_priority_field", {30'h0, tx_sel}, 32'h2);
        chk("ack own", {31'h0, ack_en}, 32'h0);
        chk("tx byte", {24'h0, tx_rd_data}, 32'ha2);
        eng.fetch(4'hc);
        chk("tx byte 12", {24'h0, tx_rd_data}, 32'h5d);
        eng.fetch(4'h0);
        eng.frame(32'h11223344, 1'b1);
        rd("rflg own", A_RFLG, 32'h0);
        eng.pulse(4'h8);
        chk("active err", {31'h0, tx_active}, 32'h0);
        txb(4'h1, 8'ha1, 8'h05);
        wr(A_TFLG, 32'h2);
        chk("tx_irq busy", {31'h0, tx_irq}, 32'h0);
        eng.pulse(4'h1);
        chk("sel retry", {30'h0, tx_sel}, 32'h1);
        eng.pulse(4'h4);
        rd("tflg sent", A_TFLG, 32'h2);
        chk("tx_irq", {31'h0, tx_irq}, 32'h1);
        eng.pulse(4'h1);
        chk("sel next", {30'h0, tx_sel}, 32'h2);
        wr(A_TCTL, 32'h75);
        rd("tflg abort", A_TFLG, 32'h13);
        eng.pulse(4'h4);
        rd("tflg done", A_TFLG, 32'h17);
    endtask

    task automatic t_loop;
        wr(A_CTRL, 32'h3);
        chk("loopback", {31'h0, loopback}, 32'h1);
        wr(A_TFLG, 32'h1);
        eng.pulse(4'h1);
        chk("ack loop", {31'h0, ack_en}, 32'h1);
        eng.frame(32'h11223344, 1'b1);
        rd("rflg loop", A_RFLG, 32'h1);
        chk("rx_irq loop", {31'h0, rx_irq}, 32'h1);
        eng.pulse(4'h4);
        wr(A_RFLG, 32'h1);
        wr(A_CTRL, 32'h2);
        wr(A_TFLG, 32'h1);
        eng.pulse(4'h1);
        eng.pulse(4'h2);
        chk("active lost", {31'h0, tx_active}, 32'h0);
        eng.frame(32'h11223344, 1'b1);
        rd("rflg lost", A_RFLG, 32'h1);
        wr(A_RFLG, 32'h1);
        eng.pulse(4'h1);
        eng.pulse(4'h4);
        rd("tflg end", A_TFLG, 32'h7);
    endtask

    // A reset in mid-run must bring back the reset values of A_CTRL, A_TFLG, A_RFLG, A_IDAC and A_PAT1, and clear tx_irq.
    task automatic t_rst_mid;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd("ctrl reset", A_CTRL, 32'h0);
        chk("tx_irq reset", {31'h0, tx_irq}, 32'h0);
        t_reset;
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_rx;
        t_ovr;
        t_modes;
        t_tx;
        t_loop;
        t_rst_mid;
        finish_test;
    end
endmodule
